// File: hw/access_field_consts.vh
// Constants for the access-control field builder: map, fields, codes.
`ifndef ACCESS_FIELD_CONSTS_VH
`define ACCESS_FIELD_CONSTS_VH
// Register byte offsets.
`define OFS_CTRL        8'h00
`define OFS_SLOT_CFG    8'h04
`define OFS_MPEG_CFG    8'h08
`define OFS_IDENT       8'h0C
`define OFS_ROUTE       8'h10
`define OFS_QUALITY     8'h14
`define OFS_MGMT        8'h18
`define OFS_REQ_VALID   8'h1C
`define OFS_STATUS      8'h20
`define OFS_REQ_BASE    8'h40
`define REQ_ADR_MASK    8'hE0
// Control register fields.
`define CTRL_START      0
`define CTRL_KIND_LO    1
`define CTRL_KIND_HI    2
`define CTRL_CONTENTION 3
// Burst kinds.
`define KIND_SYNC       2'h0
`define KIND_ATM        2'h1
`define KIND_MPEG       2'h2
// Composition fields, same layout for timeslot and packet sources.
`define CFG_ROUTE_ABSENT   0
`define CFG_QUALITY_ABSENT 1
`define CFG_REQUEST        2
`define CFG_MGMT           3
`define CFG_GROUP          4
`define CFG_LOGON          5
`define CFG_COUNT_LO       6
`define CFG_COUNT_HI       8
`define CFG_LEN_LO         16
`define CFG_LEN_HI         23
`define CFG_RESET          32'h0000_0003
// Management register fields.
`define MGMT_FINE_SYNC  0
`define MGMT_LOGOFF     1
`define MGMT_ECHO       2
`define MGMT_PAT_LO     16
`define MGMT_PAT_HI     30
// Request entry categories and management codes.
`define CAT_VOLUME      3'h0
`define CAT_RATE        3'h1
`define CAT_ABS_VOLUME  3'h2
`define MC_NONE         16'h0000
`define MC_FINE_SYNC    16'h0001
`define MC_LOGOFF       16'h0002
`define ZERO_REQUEST    16'h0000
`endif

// File: hw/req_table_mem.v
// Eight-entry capacity request table with a registered read port.
`timescale 1ns/1ps
module req_table_mem (
   // Clock
   input  wire        clk,
   // Write port
   input  wire        wr_en,
   input  wire [2:0]  wr_addr,
   input  wire [15:0] wr_data,
   // Read port
   input  wire [2:0]  rd_addr,
   output reg  [15:0] rd_data_reg
);
   reg [15:0] mem [0:7];

   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_reg <= mem[rd_addr];
   end
endmodule // req_table_mem

// File: hw/field_serializer.v
// Byte to bit serializer, most significant bit first.
`timescale 1ns/1ps
module field_serializer (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Byte side
   input  wire [7:0] byte_data,
   input  wire       byte_valid,
   input  wire       byte_first,
   input  wire       byte_last,
   output wire       byte_ready,
   // Bit side
   output reg        bit_data_reg,
   output reg        bit_valid_reg,
   output reg        bit_first_reg,
   output reg        bit_last_reg
);
   reg [7:0] shift_reg;
   reg [2:0] left_reg;
   reg       last_pend_reg;

   // A new byte is taken while the final bit of the previous one shows.
   assign byte_ready = (left_reg == 3'h0);

   always @(posedge clk) begin
      if (rst) begin
         shift_reg     <= 8'h00;
         left_reg      <= 3'h0;
         last_pend_reg <= 1'b0;
         bit_data_reg  <= 1'b0;
         bit_valid_reg <= 1'b0;
         bit_first_reg <= 1'b0;
         bit_last_reg  <= 1'b0;
      end else if (byte_valid && byte_ready) begin
         bit_data_reg  <= byte_data[7];
         shift_reg     <= {byte_data[6:0], 1'b0};
         left_reg      <= 3'h7;
         last_pend_reg <= byte_last;
         bit_valid_reg <= 1'b1;
         bit_first_reg <= byte_first;
         bit_last_reg  <= 1'b0;
      end else if (left_reg != 3'h0) begin
         bit_data_reg  <= shift_reg[7];
         shift_reg     <= {shift_reg[6:0], 1'b0};
         left_reg      <= left_reg - 3'h1;
         bit_first_reg <= 1'b0;
         bit_last_reg  <= (left_reg == 3'h1) && last_pend_reg;
      end else begin
         bit_valid_reg <= 1'b0;
         bit_first_reg <= 1'b0;
         bit_last_reg  <= 1'b0;
      end
   end
endmodule // field_serializer

// File: hw/access_field_builder.v
// Access-control field builder with a classic Wishbone register slave.
// How it works
// - Route identifier sent only when absent flag clear.
// - Request entries count from zero through configured count.
// - Entry: scale, category, channel, value; sixteen bits.
// - Scale bit selects times one or sixteen.
// - Categories volume, rate, absolute; others never sent.
// - Value units depend on category and encapsulation.
// - Channel selector zero means any channel.
// - Nothing to request sends zero volume entry.
// - Management code sent when management flag set.
// - No management message sends code zero.
// - Fine sync code only after fine sync done.
// - Echo request returns pattern in echo range.
// - Group identity sent when group flag set.
// - Logon identity sent when logon flag set.
// - Quality ratio and modcod sent when flag clear.
// - Zero bytes pad up to configured length.
// - Sub-fields appear in one fixed order.
// - Flags come from timeslot or packet composition.
// - Traffic prefix uses route and request sub-fields.
// - Contention sync bursts carry request, group, logon.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "access_field_consts.vh"
module access_field_builder (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Wishbone slave
   input  wire [7:0]  wb_adr_i,
   input  wire [31:0] wb_dat_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_we_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Serial field stream
   output wire        field_bit,
   output wire        field_valid,
   output wire        field_first,
   output wire        field_last,
   output reg         busy_reg
);
   localparam [3:0] ST_IDLE     = 4'h0;
   localparam [3:0] ST_ROUTE_HI = 4'h1;
   localparam [3:0] ST_ROUTE_LO = 4'h2;
   localparam [3:0] ST_REQ_WAIT = 4'h3;
   localparam [3:0] ST_REQ_HI   = 4'h4;
   localparam [3:0] ST_REQ_LO   = 4'h5;
   localparam [3:0] ST_MC_HI    = 4'h6;
   localparam [3:0] ST_MC_LO    = 4'h7;
   localparam [3:0] ST_GROUP    = 4'h8;
   localparam [3:0] ST_LOGON_HI = 4'h9;
   localparam [3:0] ST_LOGON_LO = 4'hA;
   localparam [3:0] ST_RATIO    = 4'hB;
   localparam [3:0] ST_MODCOD   = 4'hC;
   localparam [3:0] ST_PAD      = 4'hD;
   localparam [3:0] ST_DONE     = 4'hE;

   // Software registers.
   reg  [31:0] slot_cfg_reg;
   reg  [31:0] mpeg_cfg_reg;
   reg  [31:0] ident_reg;
   reg  [31:0] route_reg;
   reg  [31:0] quality_reg;
   reg  [1:0]  kind_reg;
   reg         contention_reg;
   reg         fine_sync_reg;
   reg  [14:0] echo_pat_reg;
   reg  [7:0]  req_valid_reg;
   reg         sync_pend_reg;
   reg         logoff_pend_reg;
   reg         echo_pend_reg;
   // Snapshot taken at the start of a field.
   reg  [5:0]  pres_reg;
   reg  [2:0]  req_last_reg;
   reg  [7:0]  len_reg;
   reg  [15:0] mc_code_reg;
   // Builder state.
   reg  [3:0]  state_reg;
   reg  [3:0]  state_next;
   reg  [2:0]  req_idx_reg;
   reg  [7:0]  byte_cnt_reg;
   reg  [7:0]  last_len_reg;
   reg  [15:0] entry_reg;
   reg  [7:0]  out_byte;
   reg         out_push;
   reg         out_last;

   wire        bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        bus_wr    = bus_req && wb_we_i;
   wire        table_hit = (wb_adr_i & `REQ_ADR_MASK) == `OFS_REQ_BASE;
   wire [15:0] mem_rd_data;
   wire        ser_ready;
   wire        start_req;
   wire [31:0] src_cfg;
   wire [5:0]  pres_cfg;
   reg  [5:0]  pres_eff;
   reg  [15:0] mc_pick;

   // Presence bit positions inside pres_reg: route, request, management,
   // group, logon, quality.
   function [3:0] first_from;
      input [3:0] from;
      input [5:0] pres;
      begin
         if (from <= ST_ROUTE_HI && pres[0]) begin
            first_from = ST_ROUTE_HI;
         end else if (from <= ST_REQ_WAIT && pres[1]) begin
            first_from = ST_REQ_WAIT;
         end else if (from <= ST_MC_HI && pres[2]) begin
            first_from = ST_MC_HI;
         end else if (from <= ST_GROUP && pres[3]) begin
            first_from = ST_GROUP;
         end else if (from <= ST_LOGON_HI && pres[4]) begin
            first_from = ST_LOGON_HI;
         end else if (from <= ST_RATIO && pres[5]) begin
            first_from = ST_RATIO;
         end else begin
            first_from = ST_PAD;
         end
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  sel;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction

   assign start_req = bus_wr && wb_adr_i == `OFS_CTRL && wb_sel_i[0] &&
                      wb_dat_i[`CTRL_START] && !busy_reg;

   // Packet bursts carry their own composition, the rest use the slot's.
   assign src_cfg  = (wb_dat_i[`CTRL_KIND_HI:`CTRL_KIND_LO] == `KIND_MPEG)
                     ? mpeg_cfg_reg : slot_cfg_reg;
   assign pres_cfg = {!src_cfg[`CFG_QUALITY_ABSENT],
                      src_cfg[`CFG_LOGON],
                      src_cfg[`CFG_GROUP],
                      src_cfg[`CFG_MGMT],
                      src_cfg[`CFG_REQUEST],
                      !src_cfg[`CFG_ROUTE_ABSENT]};

   always @* begin
      pres_eff = pres_cfg;
      case (wb_dat_i[`CTRL_KIND_HI:`CTRL_KIND_LO])
         `KIND_ATM: begin
            pres_eff = {3'h0, 1'b0, pres_cfg[1:0]};
         end
         `KIND_SYNC: begin
            if (wb_dat_i[`CTRL_CONTENTION]) begin
               pres_eff = pres_cfg | 6'h1A;
            end
         end
         default: begin
            pres_eff = pres_cfg;
         end
      endcase
   end

   // Log-off outranks echo, echo outranks the one-time sync report.
   always @* begin
      if (logoff_pend_reg) begin
         mc_pick = `MC_LOGOFF;
      end else if (echo_pend_reg) begin
         mc_pick = {1'b1, echo_pat_reg};
      end else if (sync_pend_reg && fine_sync_reg) begin
         mc_pick = `MC_FINE_SYNC;
      end else begin
         mc_pick = `MC_NONE;
      end
   end

   wire mc_taken = start_req && pres_eff[2];

   // Register writes, snapshot and pending management messages.
   always @(posedge clk) begin
      if (rst) begin
         slot_cfg_reg    <= `CFG_RESET;
         mpeg_cfg_reg    <= `CFG_RESET;
         ident_reg       <= 32'h0000_0000;
         route_reg       <= 32'h0000_0000;
         quality_reg     <= 32'h0000_0000;
         kind_reg        <= `KIND_SYNC;
         contention_reg  <= 1'b0;
         fine_sync_reg   <= 1'b0;
         echo_pat_reg    <= 15'h0000;
         req_valid_reg   <= 8'h00;
         sync_pend_reg   <= 1'b0;
         logoff_pend_reg <= 1'b0;
         echo_pend_reg   <= 1'b0;
         pres_reg        <= 6'h00;
         req_last_reg    <= 3'h0;
         len_reg         <= 8'h00;
         mc_code_reg     <= `MC_NONE;
      end else begin
         // A message is retired only when it is actually sent; a new
         // request in that same cycle stays pending.
         if (mc_taken && mc_pick == `MC_LOGOFF) begin
            logoff_pend_reg <= 1'b0;
         end
         if (mc_taken && !logoff_pend_reg && echo_pend_reg) begin
            echo_pend_reg <= 1'b0;
         end
         if (mc_taken && mc_pick == `MC_FINE_SYNC) begin
            sync_pend_reg <= 1'b0;
         end
         if (bus_wr) begin
            case (wb_adr_i)
               `OFS_SLOT_CFG: begin
                  slot_cfg_reg <= merge(slot_cfg_reg, wb_dat_i, wb_sel_i);
               end
               `OFS_MPEG_CFG: begin
                  mpeg_cfg_reg <= merge(mpeg_cfg_reg, wb_dat_i, wb_sel_i);
               end
               `OFS_IDENT: begin
                  ident_reg <= merge(ident_reg, wb_dat_i, wb_sel_i);
               end
               `OFS_ROUTE: begin
                  route_reg <= merge(route_reg, wb_dat_i, wb_sel_i);
               end
               `OFS_QUALITY: begin
                  quality_reg <= merge(quality_reg, wb_dat_i, wb_sel_i);
               end
               `OFS_REQ_VALID: begin
                  if (wb_sel_i[0]) begin
                     req_valid_reg <= wb_dat_i[7:0];
                  end
               end
               `OFS_MGMT: begin
                  if (wb_sel_i[0]) begin
                     fine_sync_reg <= wb_dat_i[`MGMT_FINE_SYNC];
                     // The report is armed on the rising sync-done level.
                     if (wb_dat_i[`MGMT_FINE_SYNC] && !fine_sync_reg) begin
                        sync_pend_reg <= 1'b1;
                     end
                     if (wb_dat_i[`MGMT_LOGOFF]) begin
                        logoff_pend_reg <= 1'b1;
                     end
                     if (wb_dat_i[`MGMT_ECHO]) begin
                        echo_pend_reg <= 1'b1;
                     end
                  end
                  if (wb_sel_i[2] && wb_sel_i[3]) begin
                     echo_pat_reg <= wb_dat_i[`MGMT_PAT_HI:`MGMT_PAT_LO];
                  end
               end
               default: begin
               end
            endcase
         end
         if (start_req) begin
            kind_reg       <= wb_dat_i[`CTRL_KIND_HI:`CTRL_KIND_LO];
            contention_reg <= wb_dat_i[`CTRL_CONTENTION];
            pres_reg       <= pres_eff;
            req_last_reg   <= src_cfg[`CFG_COUNT_HI:`CFG_COUNT_LO];
            len_reg        <= src_cfg[`CFG_LEN_HI:`CFG_LEN_LO];
            mc_code_reg    <= mc_pick;
         end
      end
   end

   // Bus answer: ack one cycle after the request, never two in a row.
   always @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0000_0000;
         if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
               `OFS_CTRL:      wb_dat_o <= {28'h000_0000, contention_reg,
                                            kind_reg, 1'b0};
               `OFS_SLOT_CFG:  wb_dat_o <= slot_cfg_reg;
               `OFS_MPEG_CFG:  wb_dat_o <= mpeg_cfg_reg;
               `OFS_IDENT:     wb_dat_o <= ident_reg;
               `OFS_ROUTE:     wb_dat_o <= route_reg;
               `OFS_QUALITY:   wb_dat_o <= quality_reg;
               `OFS_REQ_VALID: wb_dat_o <= {24'h0, req_valid_reg};
               `OFS_MGMT:      wb_dat_o <= {1'b0, echo_pat_reg, 12'h0,
                                            sync_pend_reg, echo_pend_reg,
                                            logoff_pend_reg, fine_sync_reg};
               `OFS_STATUS:    wb_dat_o <= {8'h0, last_len_reg,
                                            byte_cnt_reg, 4'h0,
                                            state_reg[3:1], busy_reg};
               default:        wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   req_table_mem u_table (
      .clk         (clk),
      .wr_en       (bus_wr && table_hit && wb_sel_i[0] && wb_sel_i[1]),
      .wr_addr     (wb_adr_i[4:2]),
      .wr_data     (wb_dat_i[15:0]),
      .rd_addr     (req_idx_reg),
      .rd_data_reg (mem_rd_data)
   );

   // An entry not marked valid, or one with a reserved category, goes out
   // as a zero volume request so the receiver never sees a bad code.
   always @* begin
      if (req_valid_reg[req_idx_reg] &&
          mem_rd_data[14:12] <= `CAT_ABS_VOLUME) begin
         entry_reg = mem_rd_data;
      end else begin
         entry_reg = `ZERO_REQUEST;
      end
   end

   // Byte sequencer in fixed sub-field order.
   always @* begin
      state_next = state_reg;
      out_byte   = 8'h00;
      out_push   = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (start_req) begin
               state_next = first_from(ST_ROUTE_HI, pres_eff);
            end
         end
         ST_ROUTE_HI: begin
            out_byte   = route_reg[15:8];
            out_push   = 1'b1;
            state_next = ST_ROUTE_LO;
         end
         ST_ROUTE_LO: begin
            out_byte   = route_reg[7:0];
            out_push   = 1'b1;
            state_next = first_from(ST_REQ_WAIT, pres_reg);
         end
         ST_REQ_WAIT: begin
            state_next = ST_REQ_HI;
         end
         ST_REQ_HI: begin
            out_byte   = entry_reg[15:8];
            out_push   = 1'b1;
            state_next = ST_REQ_LO;
         end
         ST_REQ_LO: begin
            out_byte   = entry_reg[7:0];
            out_push   = 1'b1;
            if (req_idx_reg != req_last_reg) begin
               state_next = ST_REQ_WAIT;
            end else begin
               state_next = first_from(ST_MC_HI, pres_reg);
            end
         end
         ST_MC_HI: begin
            out_byte   = mc_code_reg[15:8];
            out_push   = 1'b1;
            state_next = ST_MC_LO;
         end
         ST_MC_LO: begin
            out_byte   = mc_code_reg[7:0];
            out_push   = 1'b1;
            state_next = first_from(ST_GROUP, pres_reg);
         end
         ST_GROUP: begin
            out_byte   = ident_reg[23:16];
            out_push   = 1'b1;
            state_next = first_from(ST_LOGON_HI, pres_reg);
         end
         ST_LOGON_HI: begin
            out_byte   = ident_reg[15:8];
            out_push   = 1'b1;
            state_next = ST_LOGON_LO;
         end
         ST_LOGON_LO: begin
            out_byte   = ident_reg[7:0];
            out_push   = 1'b1;
            state_next = first_from(ST_RATIO, pres_reg);
         end
         ST_RATIO: begin
            out_byte   = quality_reg[7:0];
            out_push   = 1'b1;
            state_next = ST_MODCOD;
         end
         ST_MODCOD: begin
            out_byte   = quality_reg[15:8];
            out_push   = 1'b1;
            state_next = ST_PAD;
         end
         ST_PAD: begin
            // Content longer than the setting is never cut short.
            if (byte_cnt_reg < len_reg) begin
               out_byte   = 8'h00;
               out_push   = 1'b1;
               state_next = ST_PAD;
            end else begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            if (ser_ready) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // A byte state holds until the serializer takes its byte.
      if (out_push && !ser_ready) begin
         state_next = state_reg;
      end
      out_last = out_push && state_next == ST_PAD &&
                 (byte_cnt_reg + 8'h01) >= len_reg;
   end

   always @(posedge clk) begin
      if (rst) begin
         state_reg    <= ST_IDLE;
         req_idx_reg  <= 3'h0;
         byte_cnt_reg <= 8'h00;
         last_len_reg <= 8'h00;
         busy_reg     <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (start_req) begin
            busy_reg     <= 1'b1;
            byte_cnt_reg <= 8'h00;
            req_idx_reg  <= 3'h0;
         end else if (out_push && ser_ready) begin
            byte_cnt_reg <= byte_cnt_reg + 8'h01;
            if (state_reg == ST_REQ_LO) begin
               req_idx_reg <= req_idx_reg + 3'h1;
            end
         end
         if (state_reg == ST_DONE && ser_ready) begin
            busy_reg     <= 1'b0;
            last_len_reg <= byte_cnt_reg;
         end
      end
   end

   field_serializer u_ser (
      .clk           (clk),
      .rst           (rst),
      .byte_data     (out_byte),
      .byte_valid    (out_push),
      .byte_first    (byte_cnt_reg == 8'h00),
      .byte_last     (out_last),
      .byte_ready    (ser_ready),
      .bit_data_reg  (field_bit),
      .bit_valid_reg (field_valid),
      .bit_first_reg (field_first),
      .bit_last_reg  (field_last)
   );
endmodule // access_field_builder

// File: tb/afb_assertions.sv
// Port-level checker for the access-control field builder.
`timescale 1ns/1ps
module afb_checker (
   // Clock and reset
   input wire        clk,
   input wire        rst,
   // Wishbone slave
   input wire [7:0]  wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0]  wb_sel_i,
   input wire        wb_we_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // Field stream
   input wire        field_valid,
   input wire        field_first,
   input wire        field_last,
   input wire        busy_reg
);
   wire start_req;
   assign start_req = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] &
                      wb_dat_i[0] & (wb_adr_i == 8'h00);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("dat idle");
   property p_start; $rose(busy_reg) |-> $past(start_req); endproperty
   a_start: assert property (p_start) else $error("busy no start");
   property p_valid_busy; field_valid |-> busy_reg; endproperty
   a_valid_busy: assert property (p_valid_busy) else $error("bit idle");
   property p_first; field_first |-> field_valid ##1 !field_first; endproperty
   a_first: assert property (p_first) else $error("first bad");
   property p_last; field_last |-> field_valid ##1 !field_valid; endproperty
   a_last: assert property (p_last) else $error("last bad");
   property p_end; field_last |-> ##[1:3] !busy_reg; endproperty
   a_end: assert property (p_end) else $error("busy stuck");
   c_frame: cover property (field_last);
   c_start: cover property ($rose(busy_reg));
   c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // afb_checker
bind access_field_builder afb_checker afb_checker_inst (.clk(clk),
   .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .field_valid(field_valid),
   .field_first(field_first), .field_last(field_last), .busy_reg(busy_reg));

// File: tb/field_receiver.sv
// Burst receiver model that gathers the serial field back into bytes.
`timescale 1ns/1ps
module field_receiver (
   // Clock
   input wire clk,
   // Serial field
   input wire field_bit,
   input wire field_valid,
   input wire field_first,
   input wire field_last
);
   logic [7:0] rx_bytes [0:31];
   logic [7:0] shift_reg;
   int         bit_count = 0;
   logic       rx_last = 1'b0;
   // Bits pack most significant first into bytes in arrival order.
   always @(posedge clk) begin
      if (field_valid) begin
         if (field_first) begin
            bit_count = 0;
            rx_last = 1'b0;
         end
         shift_reg = {shift_reg[6:0], field_bit};
         if (bit_count % 8 == 7 && bit_count < 256) begin
            rx_bytes[bit_count / 8] = shift_reg;
         end
         bit_count = bit_count + 1;
         rx_last = rx_last | field_last;
      end
   end
endmodule // field_receiver

// File: tb/tb_top.sv
// Self-checking bench for the access-control field builder.
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [3:0]  wb_sel_i = 4'h0;
   logic        wb_we_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, field_bit, field_valid, field_first;
   wire         field_last, busy_reg;
   int          mismatches = 0;
   int          check_count = 0;
   int          cycles = 0;
   always #2 clk = ~clk;
   access_field_builder access_field_builder_inst (.clk(clk), .rst(rst),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .field_bit(field_bit),
      .field_valid(field_valid), .field_first(field_first),
      .field_last(field_last), .busy_reg(busy_reg));
   field_receiver field_receiver_inst (.clk(clk), .field_bit(field_bit),
      .field_valid(field_valid), .field_first(field_first),
      .field_last(field_last));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // A hung handshake or frame ends the run here.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic [31:0] d,
                     input logic w, output logic [31:0] q);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_we_i <= w;
      wb_sel_i <= 4'hF;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(a, d, 1'b1, q);
   endtask
   // Starts one field and compares every byte the receiver gathered.
   task automatic run_frame(input logic [7:0] ctrl, input int n,
                            input logic [0:15][7:0] e);
      wr(8'h00, {24'h00_0000, ctrl});
      do @(posedge clk); while (busy_reg !== 1'b0);
      chk("bytes", field_receiver_inst.bit_count / 8, n);
      for (int i = 0; i < n; i++) begin
         chk("byte", field_receiver_inst.rx_bytes[i], e[i]);
      end
   endtask
   task automatic t_regs;
      logic [31:0] q;
      wb(8'h04, 32'h0000_0000, 1'b0, q);
      chk("slot cfg", q, 32'h0000_0003);
      wb(8'h08, 32'h0000_0000, 1'b0, q);
      chk("packet cfg", q, 32'h0000_0003);
      wr(8'h24, 32'hFFFF_FFFF);
      wb(8'h24, 32'h0000_0000, 1'b0, q);
      chk("unmapped", q, 32'h0000_0000);
      $display("test registers done");
   endtask
   task automatic t_full;
      wr(8'h10, 32'h0000_A5C3);
      wr(8'h0C, 32'h005A_1234);
      wr(8'h14, 32'h0000_0E66);
      wr(8'h40, 32'h0000_9025);
      wr(8'h44, 32'h0000_237F);
      wr(8'h1C, 32'h0000_0003);
      wr(8'h18, 32'h1357_0004);
      wr(8'h04, 32'h000F_007C);
      run_frame(8'h01, 15, 128'hA5C3_9025_237F_9357_5A12_3466_0E00_0000);
      chk("last", field_receiver_inst.rx_last, 32'h0000_0001);
      $display("test full field done");
   endtask
   task automatic t_atm;
      run_frame(8'h03, 15, 128'hA5C3_9025_237F_0000_0000_0000_0000_0000);
      $display("test prefix done");
   endtask
   task automatic t_mgmt;
      wr(8'h04, 32'h0002_000B);
      wr(8'h18, 32'h0000_0001);
      run_frame(8'h01, 2, 128'h0001_0000_0000_0000_0000_0000_0000_0000);
      run_frame(8'h01, 2, 128'h0000_0000_0000_0000_0000_0000_0000_0000);
      wr(8'h18, 32'h0000_0003);
      run_frame(8'h01, 2, 128'h0002_0000_0000_0000_0000_0000_0000_0000);
      $display("test management done");
   endtask
   task automatic t_mpeg;
      logic [31:0] q;
      wr(8'h18, 32'h0000_0000);
      wr(8'h40, 32'h0000_3044);
      wr(8'h44, 32'h0000_0F10);
      wr(8'h08, 32'h0008_008F);
      run_frame(8'h05, 8, 128'h0000_0F10_0000_0000_0000_0000_0000_0000);
      run_frame(8'h09, 7, 128'h0000_0000_5A12_3400_0000_0000_0000_0000);
      wb(8'h00, 32'h0000_0000, 1'b0, q);
      chk("ctrl", q, 32'h0000_0008);
      $display("test packet and contention done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_full();
      t_atm();
      t_mgmt();
      t_mpeg();
      print_verdict();
   end
endmodule // tb_top
